// file: hdl/mie_alu.sv
`timescale 1ns/100ps
`default_nettype none

module mie_alu (
    // Operation and operands
    input wire mie_pkg::mie_op_t op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic [2:0] bit_sel,
    input wire logic carry_in,
    input wire logic half_in,
    // Result
    output var mie_pkg::mie_alu_out_t res
);
    import mie_pkg::*;

    logic [8:0] sum;
    logic [4:0] lo_sum;
    logic cin;
    logic [7:0] daa_fix;
    logic [8:0] daa_sum;

    assign cin = (op == MIE_OP_ADC) ? carry_in : 1'b0;
    assign sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    assign lo_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};

    always_comb begin
        daa_fix = MIE_ZERO_BYTE;
        if ((a[3:0] > MIE_BCD_LIMIT) || half_in) begin
            daa_fix[3:0] = MIE_BCD_FIX;
        end
        if ((a[7:4] > MIE_BCD_LIMIT) || carry_in) begin
            daa_fix[7:4] = MIE_BCD_FIX;
        end
    end
    assign daa_sum = {1'b0, a} + {1'b0, daa_fix};

    always_comb begin
        res = '0;
        unique case (op)
            MIE_OP_ADD, MIE_OP_ADC: begin
                res.value = sum[7:0];
                res.c = sum[8];
                res.hc = lo_sum[4];
                res.ov = (a[7] == b[7]) && (sum[7] != a[7]);
                res.sc = res.ov ^ sum[7];
            end
            MIE_OP_AND: res.value = a & b;
            MIE_OP_OR: res.value = a | b;
            MIE_OP_CPL: res.value = ~b;
            MIE_OP_INC: res.value = b + 8'h01;
            MIE_OP_DEC: res.value = b - 8'h01;
            MIE_OP_MOV_A_M: res.value = b;
            MIE_OP_MOV_A_X: res.value = b;
            MIE_OP_MOV_M_A: res.value = a;
            MIE_OP_CLR: res.value = MIE_ZERO_BYTE;
            MIE_OP_CLR_BIT: begin
                res.value = b;
                res.value[bit_sel] = 1'b0;
            end
            MIE_OP_DAA: begin
                res.value = daa_sum[7:0];
                res.c = daa_sum[8] | carry_in;
            end
            MIE_OP_RET_A: res.value = b;
            default: res.value = a;
        endcase
        res.z = (res.value == MIE_ZERO_BYTE);
    end
endmodule // mie_alu

`default_nettype wire

// file: hdl/mie_core.sv
`timescale 1ns/100ps
`default_nettype none

module mie_core #(
    parameter int STACK_DEPTH = 8,
    parameter int WDT_W = 16,
    parameter int PS_W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Instruction issue
    input wire mie_pkg::mie_instr_t instr,
    input wire logic instr_valid,
    output logic instr_ready,
    // Data memory
    output logic [7:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    output logic [7:0] mem_wdata,
    output logic mem_we,
    // Interrupts
    input wire logic irq_pending,
    input wire logic wake,
    output logic global_irq_enable,
    output logic irq_take,
    // Status
    output logic [7:0] acc,
    output logic [12:0] pc,
    output var mie_pkg::mie_flags_t flags,
    output logic halted,
    output logic [WDT_W-1:0] watchdog_counter,
    output logic watchdog_timeout_flag,
    output logic powerdown_flag
);
    import mie_pkg::*;

    typedef enum logic [1:0] {
        MIE_ST_RUN,
        MIE_ST_DUMMY,
        MIE_ST_HALT
    } mie_state_t;

    localparam int SPW = $clog2(STACK_DEPTH);

    mie_state_t state_reg;
    mie_state_t state_next;
    logic [12:0] stack_reg [STACK_DEPTH];
    logic [SPW-1:0] sp_reg;
    logic go;
    logic wake_s1;
    logic wake_s2;
    logic [7:0] operand;
    mie_alu_out_t alu;
    logic is_add;
    logic is_logic;
    logic to_mem_w;
    logic to_acc_w;
    logic push;
    logic pop;

    // ----------------------------------------------------------------
    // Issue control
    // ----------------------------------------------------------------
    assign instr_ready = (state_reg == MIE_ST_RUN);
    assign go = instr_valid && instr_ready;
    assign mem_addr = instr.addr;
    assign operand = instr.use_imm ? instr.imm : mem_rdata;

    // Wake comes from outside the clock domain
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
        end else begin
            wake_s1 <= wake;
            wake_s2 <= wake_s1;
        end
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            MIE_ST_RUN: begin
                if (go) begin
                    unique case (instr.op)
                        MIE_OP_CALL: state_next = MIE_ST_DUMMY;
                        MIE_OP_JMP: state_next = MIE_ST_DUMMY;
                        MIE_OP_HALT: state_next = MIE_ST_HALT;
                        default: state_next = MIE_ST_RUN;
                    endcase
                end
            end
            MIE_ST_DUMMY: state_next = MIE_ST_RUN;
            MIE_ST_HALT: begin
                if (wake_s2) begin
                    state_next = MIE_ST_RUN;
                end
            end
            // Unused code falls back to running
            default: state_next = MIE_ST_RUN;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= MIE_ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end
    assign halted = (state_reg == MIE_ST_HALT);

    // ----------------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------------
    mie_alu u_alu (
        .op(instr.op),
        .a(acc),
        .b(operand),
        .bit_sel(instr.bit_sel),
        .carry_in(flags.carry_flag),
        .half_in(flags.half_carry_flag),
        .res(alu)
    );

    assign is_add = (instr.op == MIE_OP_ADD) || (instr.op == MIE_OP_ADC);
    assign is_logic = (instr.op == MIE_OP_AND) || (instr.op == MIE_OP_OR);

    always_comb begin
        to_mem_w = 1'b0;
        to_acc_w = 1'b0;
        unique case (instr.op)
            MIE_OP_ADD, MIE_OP_ADC: begin
                to_mem_w = instr.to_mem;
                to_acc_w = !instr.to_mem;
            end
            MIE_OP_AND, MIE_OP_OR: begin
                to_mem_w = instr.to_mem;
                to_acc_w = !instr.to_mem;
            end
            MIE_OP_CPL, MIE_OP_INC, MIE_OP_DEC: begin
                to_mem_w = instr.to_mem;
                to_acc_w = !instr.to_mem;
            end
            MIE_OP_MOV_A_M, MIE_OP_MOV_A_X: to_acc_w = 1'b1;
            MIE_OP_MOV_M_A: to_mem_w = 1'b1;
            MIE_OP_CLR, MIE_OP_CLR_BIT: to_mem_w = 1'b1;
            MIE_OP_DAA: to_mem_w = 1'b1;
            MIE_OP_RET_A: to_acc_w = 1'b1;
            default: begin
                to_mem_w = 1'b0;
                to_acc_w = 1'b0;
            end
        endcase
    end

    // Write strobe is combinational, data comes straight from the ALU
    assign mem_we = go && to_mem_w;
    assign mem_wdata = alu.value;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            acc <= MIE_ACC_RST;
        end else if (go && to_acc_w) begin
            acc <= alu.value;
        end
    end

    // ----------------------------------------------------------------
    // Flags
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flags <= '0;
        end else if (go) begin
            if (is_add) begin
                flags.signed_wrap_flag <= alu.ov;
                flags.zero_flag <= alu.z;
                flags.half_carry_flag <= alu.hc;
                flags.carry_flag <= alu.c;
                flags.extra_sign_flag <= alu.sc;
            end else if (is_logic || (instr.op == MIE_OP_CPL) ||
                         (instr.op == MIE_OP_INC) ||
                         (instr.op == MIE_OP_DEC)) begin
                flags.zero_flag <= alu.z;
            end else if (instr.op == MIE_OP_DAA) begin
                flags.carry_flag <= alu.c;
            end
        end
    end

    // ----------------------------------------------------------------
    // Program counter and stack
    // ----------------------------------------------------------------
    assign push = go && (instr.op == MIE_OP_CALL);
    assign pop = go && ((instr.op == MIE_OP_RET) ||
                        (instr.op == MIE_OP_RET_A) ||
                        (instr.op == MIE_OP_INTERRUPT_RETURN_OP));

    // Stack wraps silently on overflow; depth is a software concern
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sp_reg <= '0;
        end else if (push) begin
            sp_reg <= sp_reg + 1'b1;
        end else if (pop) begin
            sp_reg <= sp_reg - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            stack_reg[sp_reg] <= pc + 13'h0001;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pc <= MIE_PC_RST;
        end else if (go) begin
            unique case (instr.op)
                MIE_OP_CALL, MIE_OP_JMP: pc <= instr.target;
                MIE_OP_RET, MIE_OP_RET_A, MIE_OP_INTERRUPT_RETURN_OP:
                    pc <= stack_reg[sp_reg - 1'b1];
                default: pc <= pc + 13'h0001;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            global_irq_enable <= 1'b0;
        end else if (go && (instr.op == MIE_OP_INTERRUPT_RETURN_OP)) begin
            global_irq_enable <= 1'b1;
        end else if (irq_take) begin
            global_irq_enable <= 1'b0;
        end
    end

    assign irq_take = global_irq_enable && irq_pending &&
                      (state_reg == MIE_ST_RUN) && !go;

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    mie_wdt #(
        .WDT_W(WDT_W),
        .PS_W(PS_W)
    ) u_wdt (
        .mclk(mclk),
        .rst(rst),
        .clear_req(go && (instr.op == MIE_OP_CLR_WDT)),
        .halt_req(go && (instr.op == MIE_OP_HALT)),
        .halted(halted),
        .watchdog_counter(watchdog_counter),
        .watchdog_timeout_flag(watchdog_timeout_flag),
        .powerdown_flag(powerdown_flag)
    );
endmodule // mie_core

`default_nettype wire

// file: hdl/mie_pkg.sv
`default_nettype none

package mie_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int MIE_DW = 8;
    localparam int MIE_AW = 8;
    localparam int MIE_PCW = 13;
    localparam int MIE_WDTW = 16;
    localparam int MIE_PSW = 8;

    // ----------------------------------------------------------------
    // Constants
    // ----------------------------------------------------------------
    localparam logic [7:0] MIE_ZERO_BYTE = 8'h00;
    localparam logic [3:0] MIE_BCD_LIMIT = 4'h9;
    localparam logic [3:0] MIE_BCD_FIX = 4'h6;
    localparam logic [7:0] MIE_ACC_RST = 8'h00;
    localparam logic [12:0] MIE_PC_RST = 13'h0000;
    localparam logic [1:0] MIE_CYC_ONE = 2'h1;
    localparam logic [1:0] MIE_CYC_TWO = 2'h2;

    // ----------------------------------------------------------------
    // Operations
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        MIE_OP_NOP,
        MIE_OP_ADD,
        MIE_OP_ADC,
        MIE_OP_AND,
        MIE_OP_OR,
        MIE_OP_CPL,
        MIE_OP_INC,
        MIE_OP_DEC,
        MIE_OP_MOV_A_M,
        MIE_OP_MOV_A_X,
        MIE_OP_MOV_M_A,
        MIE_OP_CLR,
        MIE_OP_CLR_BIT,
        MIE_OP_DAA,
        MIE_OP_CALL,
        MIE_OP_JMP,
        MIE_OP_RET,
        MIE_OP_RET_A,
        MIE_OP_INTERRUPT_RETURN_OP,
        MIE_OP_CLR_WDT,
        MIE_OP_HALT
    } mie_op_t;

    // Instruction as handed in by the fetch logic
    typedef struct packed {
        mie_op_t op;
        logic to_mem;
        logic use_imm;
        logic [7:0] imm;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [12:0] target;
    } mie_instr_t;

    typedef struct packed {
        logic signed_wrap_flag;
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
        logic extra_sign_flag;
    } mie_flags_t;

    typedef struct packed {
        logic [7:0] value;
        logic z;
        logic hc;
        logic c;
        logic ov;
        logic sc;
    } mie_alu_out_t;

endpackage : mie_pkg

`default_nettype wire

// file: hdl/mie_wdt.sv
`timescale 1ns/100ps
`default_nettype none

module mie_wdt #(
    parameter int WDT_W = 16,
    parameter int PS_W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control
    input wire logic clear_req,
    input wire logic halt_req,
    input wire logic halted,
    // Status
    output logic [WDT_W-1:0] watchdog_counter,
    output logic watchdog_timeout_flag,
    output logic powerdown_flag
);
    import mie_pkg::*;

    logic [PS_W-1:0] presc_reg;
    logic tick;

    assign tick = &presc_reg;

    // Prescaler and counter, held while the core is in the halt state
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            presc_reg <= '0;
            watchdog_counter <= '0;
        end else if (clear_req || halt_req) begin
            presc_reg <= '0;
            watchdog_counter <= '0;
        end else if (!halted) begin
            presc_reg <= presc_reg + 1'b1;
            if (tick) begin
                watchdog_counter <= watchdog_counter + 1'b1;
            end
        end
    end

    // Timeout set wins over nothing: clears are instruction-driven only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            watchdog_timeout_flag <= 1'b0;
        end else if (clear_req || halt_req) begin
            watchdog_timeout_flag <= 1'b0;
        end else if (!halted && tick && (&watchdog_counter)) begin
            watchdog_timeout_flag <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            powerdown_flag <= 1'b0;
        end else if (halt_req) begin
            powerdown_flag <= 1'b1;
        end else if (clear_req) begin
            powerdown_flag <= 1'b0;
        end
    end
endmodule // mie_wdt

`default_nettype wire

// file: verif/mie_core_checker.sv
`timescale 1ns/100ps
`default_nettype none

module mie_core_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Issue
    input wire mie_pkg::mie_instr_t instr,
    input wire logic instr_valid,
    input wire logic instr_ready,
    // Memory
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_we,
    // Status
    input wire logic global_irq_enable,
    input wire logic [12:0] pc,
    input wire mie_pkg::mie_flags_t flags,
    input wire logic halted,
    input wire logic watchdog_timeout_flag,
    input wire logic powerdown_flag
);
    import mie_pkg::*;

    logic take;
    mie_op_t op;
    assign take = instr_valid && instr_ready;
    assign op = instr.op;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_jmp_pc;
        take && op == MIE_OP_JMP |=> pc == $past(instr.target);
    endproperty
    a_jmp_pc: assert property (p_jmp_pc)
        else $error("jump target not loaded");
    property p_two_cyc;
        take && op inside {MIE_OP_JMP, MIE_OP_CALL}
            |=> !instr_ready ##1 instr_ready;
    endproperty
    a_two_cyc: assert property (p_two_cyc)
        else $error("branch did not take two cycles");
    property p_one_cyc;
        take && !(op inside {MIE_OP_JMP, MIE_OP_CALL, MIE_OP_HALT})
            |=> instr_ready;
    endproperty
    a_one_cyc: assert property (p_one_cyc)
        else $error("single cycle op stalled issue");
    property p_flag_keep;
        take && op inside {MIE_OP_MOV_A_M, MIE_OP_MOV_A_X, MIE_OP_MOV_M_A,
            MIE_OP_CLR, MIE_OP_CLR_BIT, MIE_OP_NOP, MIE_OP_RET_A}
            |=> $stable(flags);
    endproperty
    a_flag_keep: assert property (p_flag_keep)
        else $error("flags changed by flagless op");
    property p_zero_only;
        take && op inside {MIE_OP_AND, MIE_OP_OR, MIE_OP_CPL, MIE_OP_INC,
            MIE_OP_DEC} |=> $stable({flags.signed_wrap_flag,
            flags.half_carry_flag, flags.carry_flag, flags.extra_sign_flag});
    endproperty
    a_zero_only: assert property (p_zero_only)
        else $error("non-zero flag changed");
    property p_clr;
        take && op == MIE_OP_CLR |-> mem_we && mem_wdata == 8'h00;
    endproperty
    a_clr: assert property (p_clr)
        else $error("byte clear wrote nonzero");
    property p_clr_bit;
        take && op == MIE_OP_CLR_BIT |-> mem_we
            && mem_wdata == (mem_rdata & ~(8'h01 << instr.bit_sel));
    endproperty
    a_clr_bit: assert property (p_clr_bit)
        else $error("bit clear wrote wrong byte");
    property p_wdt_clr;
        take && op == MIE_OP_CLR_WDT
            |=> !watchdog_timeout_flag && !powerdown_flag;
    endproperty
    a_wdt_clr: assert property (p_wdt_clr)
        else $error("watchdog clear left a flag set");
    property p_halt;
        take && op == MIE_OP_HALT
            |=> halted && powerdown_flag && !watchdog_timeout_flag;
    endproperty
    a_halt: assert property (p_halt)
        else $error("halt entry state wrong");
    property p_interrupt_return_op;
        take && op == MIE_OP_INTERRUPT_RETURN_OP |=> global_irq_enable;
    endproperty
    a_interrupt_return_op: assert property (p_interrupt_return_op)
        else $error("interrupt return left enable low");
    property p_daa_flags;
        take && op == MIE_OP_DAA |=> $stable({flags.signed_wrap_flag,
            flags.zero_flag, flags.half_carry_flag, flags.extra_sign_flag});
    endproperty
    a_daa_flags: assert property (p_daa_flags)
        else $error("decimal adjust changed a non-carry flag");
    property p_inc_mem;
        take && op == MIE_OP_INC && instr.to_mem && !instr.use_imm
            |-> mem_we && mem_wdata == mem_rdata + 8'h01;
    endproperty
    a_inc_mem: assert property (p_inc_mem)
        else $error("increment wrote wrong byte");
endmodule // mie_core_checker

bind mie_core mie_core_checker u_chk (.mclk(mclk), .rst(rst), .instr(instr),
    .instr_valid(instr_valid), .instr_ready(instr_ready),
    .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .global_irq_enable(global_irq_enable), .pc(pc), .flags(flags),
    .halted(halted), .watchdog_timeout_flag(watchdog_timeout_flag),
    .powerdown_flag(powerdown_flag));

`default_nettype wire

// file: verif/mie_core_tb.sv
`timescale 1ns/100ps
`default_nettype none

module mie_core_tb;
    import mie_pkg::*;

    typedef struct packed {
        mie_instr_t ins;
        logic [7:0] acc;
        logic [7:0] mb;
        logic [4:0] fl;
    } mie_row_t;

    logic mclk, rst, instr_valid, instr_ready, mem_we, irq_pending, wake;
    logic global_irq_enable, irq_take, halted, wd_to, pd_flag;
    logic [7:0] mem_addr, mem_rdata, mem_wdata, acc;
    logic [12:0] pc;
    logic [3:0] wd_cnt;
    mie_instr_t instr;
    mie_flags_t flags;
    mie_row_t rows [19];
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;

    // Small watchdog so a timeout shows within 64 cycles
    mie_core #(.WDT_W(4), .PS_W(2)) uut (.mclk(mclk), .rst(rst),
        .instr(instr), .instr_valid(instr_valid), .instr_ready(instr_ready),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .irq_pending(irq_pending), .wake(wake),
        .global_irq_enable(global_irq_enable), .irq_take(irq_take),
        .acc(acc), .pc(pc), .flags(flags), .halted(halted),
        .watchdog_counter(wd_cnt), .watchdog_timeout_flag(wd_to),
        .powerdown_flag(pd_flag));

    mie_dmem_model u_mem (.mclk(mclk), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    function automatic mie_instr_t mk(mie_op_t op, logic tm, logic ui,
            logic [7:0] v, logic [7:0] a);
        mk = '{op, tm, ui, v, a, v[2:0], {5'h01, v}};
    endfunction

    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Wait for ready, hold the request over one accept edge, then release
    task automatic issue(mie_instr_t i);
        int n;
        n = 0;
        while (instr_ready !== 1'b1 && n < 20) begin
            @(posedge mclk);
            #1;
            n++;
        end
        @(posedge mclk);
        instr <= i;
        instr_valid <= 1'b1;
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
    endtask

    // Hang guard: the whole run needs under two hundred cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            finish_test();
        end
    end

    initial begin
        int n;
        rst = 1'b1;
        instr_valid = 1'b0;
        instr = '0;
        irq_pending = 1'b0;
        wake = 1'b0;
        rows[0] = '{mk(MIE_OP_MOV_A_X, 0, 1, 8'h3C, 8'h00),
            8'h3C, 8'h00, 5'h00};
        rows[1] = '{mk(MIE_OP_ADD, 0, 1, 8'hC8, 8'h00), 8'h04, 8'h00, 5'h06};
        rows[2] = '{mk(MIE_OP_ADC, 0, 0, 8'h00, 8'h7F), 8'h84, 8'h7F, 5'h14};
        rows[3] = '{mk(MIE_OP_ADD, 1, 0, 8'h00, 8'h7C), 8'h84, 8'h00, 5'h0E};
        rows[4] = '{mk(MIE_OP_AND, 0, 0, 8'h00, 8'h0F), 8'h04, 8'h0F, 5'h06};
        rows[5] = '{mk(MIE_OP_OR, 1, 0, 8'h00, 8'h30), 8'h04, 8'h34, 5'h06};
        rows[6] = '{mk(MIE_OP_CPL, 0, 0, 8'h00, 8'hFF), 8'h00, 8'hFF, 5'h0E};
        rows[7] = '{mk(MIE_OP_INC, 1, 0, 8'h00, 8'hFF), 8'h00, 8'h00, 5'h0E};
        rows[8] = '{mk(MIE_OP_DEC, 0, 0, 8'h00, 8'h01), 8'h00, 8'h01, 5'h0E};
        rows[9] = '{mk(MIE_OP_MOV_A_M, 0, 0, 8'h00, 8'h99),
            8'h99, 8'h99, 5'h0E};
        rows[10] = '{mk(MIE_OP_ADD, 0, 1, 8'h99, 8'h00), 8'h32, 8'h00, 5'h17};
        rows[11] = '{mk(MIE_OP_DAA, 1, 0, 8'h00, 8'h40), 8'h32, 8'h98, 5'h17};
        rows[12] = '{mk(MIE_OP_MOV_A_X, 0, 1, 8'h50, 8'h00),
            8'h50, 8'h00, 5'h17};
        rows[13] = '{mk(MIE_OP_ADD, 0, 1, 8'h60, 8'h00), 8'hB0, 8'h00, 5'h10};
        rows[14] = '{mk(MIE_OP_DAA, 1, 0, 8'h00, 8'h41), 8'hB0, 8'h10, 5'h12};
        rows[15] = '{mk(MIE_OP_CLR, 1, 0, 8'h00, 8'h50), 8'hB0, 8'h00, 5'h12};
        rows[16] = '{mk(MIE_OP_CLR_BIT, 1, 0, 8'h03, 8'h7F),
            8'hB0, 8'h77, 5'h12};
        rows[17] = '{mk(MIE_OP_MOV_M_A, 1, 0, 8'h00, 8'h60),
            8'hB0, 8'hB0, 5'h12};
        rows[18] = '{mk(MIE_OP_NOP, 0, 0, 8'h00, 8'h61), 8'hB0, 8'h61, 5'h12};
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk("acc", 16'(acc), 16'h0000);
        chk("ready", 16'(instr_ready), 16'h0001);
        for (int i = 0; i < 19; i++) begin
            issue(rows[i].ins);
            chk("acc", 16'(acc), 16'(rows[i].acc));
            chk("mem", 16'(u_mem.mem[mem_addr]), 16'(rows[i].mb));
            chk("flags", 16'(flags), 16'(rows[i].fl));
        end
        chk("pc", 16'(pc), 16'h0013);
        issue(mk(MIE_OP_JMP, 1'b0, 1'b0, 8'h23, 8'h00));
        chk("pc", 16'(pc), 16'h0123);
        chk("ready", 16'(instr_ready), 16'h0000);
        issue(mk(MIE_OP_CALL, 1'b0, 1'b0, 8'h56, 8'h00));
        chk("pc", 16'(pc), 16'h0156);
        issue(mk(MIE_OP_RET_A, 1'b0, 1'b1, 8'h5A, 8'h00));
        chk("pc", 16'(pc), 16'h0124);
        chk("acc", 16'(acc), 16'h005A);
        chk("flags", 16'(flags), 16'h0012);
        issue(mk(MIE_OP_CALL, 1'b0, 1'b0, 8'h77, 8'h00));
        issue(mk(MIE_OP_RET, 1'b0, 1'b0, 8'h00, 8'h00));
        chk("pc", 16'(pc), 16'h0125);
        @(posedge mclk) irq_pending <= 1'b1;
        issue(mk(MIE_OP_CALL, 1'b0, 1'b0, 8'h78, 8'h00));
        issue(mk(MIE_OP_INTERRUPT_RETURN_OP, 1'b0, 1'b0, 8'h00, 8'h00));
        chk("pc", 16'(pc), 16'h0126);
        chk("irq_en", 16'(global_irq_enable), 16'h0001);
        chk("irq_take", 16'(irq_take), 16'h0001);
        @(posedge mclk) irq_pending <= 1'b0;
        repeat (80) @(posedge mclk);
        #1;
        chk("timeout", 16'(wd_to), 16'h0001);
        chk("irq_en", 16'(global_irq_enable), 16'h0000);
        issue(mk(MIE_OP_CLR_WDT, 1'b0, 1'b0, 8'h00, 8'h00));
        chk("timeout", 16'(wd_to), 16'h0000);
        chk("wd_cnt", 16'(wd_cnt), 16'h0000);
        issue(mk(MIE_OP_HALT, 1'b0, 1'b0, 8'h00, 8'h00));
        chk("halted", 16'(halted), 16'h0001);
        chk("pd_flag", 16'(pd_flag), 16'h0001);
        chk("ready", 16'(instr_ready), 16'h0000);
        @(posedge mclk) wake <= 1'b1;
        n = 0;
        while (instr_ready !== 1'b1 && n < 10) begin
            @(posedge mclk);
            #1;
            n++;
        end
        @(posedge mclk) wake <= 1'b0;
        #1;
        chk("acc", 16'(acc), 16'h005A);
        issue(mk(MIE_OP_CLR_WDT, 1'b0, 1'b0, 8'h00, 8'h00));
        chk("pd_flag", 16'(pd_flag), 16'h0000);
        finish_test();
    end
endmodule // mie_core_tb

`default_nettype wire

// file: verif/mie_dmem_model.sv
`timescale 1ns/100ps
`default_nettype none

module mie_dmem_model (
    // Clock
    input wire logic mclk,
    // Data memory port
    input wire logic [7:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_we,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [256];

    // Each byte holds its own address, so expectations need no preload
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i);
        end
    end

    // Same-cycle read: the core uses the byte in its accept cycle
    assign mem_rdata = mem[mem_addr];

    always @(posedge mclk) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule // mie_dmem_model

`default_nettype wire
